// ==== shared/keyscan_wakeup_pkg.sv ====
// constants for the keyscan and wakeup control block
package keyscan_wakeup_pkg;
    // ********************
    // register offsets
    // ********************
    localparam logic [7:0] OFS_SCAN_CTL = 8'h40;
    localparam logic [7:0] OFS_SCAN_LEVEL = 8'h41;
    localparam logic [7:0] OFS_SCAN_FLAGS = 8'h42;
    localparam logic [7:0] OFS_SCAN_IRQ_EN = 8'h43;
    localparam logic [7:0] OFS_SOFT_RESET = 8'hF5;
    localparam logic [7:0] OFS_FACTORY_TEST = 8'hF6;
    localparam logic [7:0] OFS_GROUP_SUMMARY = 8'hF9;
    localparam logic [7:0] OFS_OSC_LINK_CTL = 8'hFA;
    localparam logic [7:0] OFS_WAKE_EN = 8'hFB;
    localparam logic [7:0] OFS_PART_ID = 8'hFC;
    localparam logic [7:0] OFS_REVISION = 8'hFD;
    localparam logic [7:0] OFS_MAKER_LOW = 8'hFE;
    localparam logic [7:0] OFS_MAKER_HIGH = 8'hFF;
    // ********************
    // reset values and fields
    // ********************
    localparam logic [7:0] SCAN_CTL_RESET = 8'h40;
    localparam int SCAN_POL_BIT = 7;
    localparam int SCAN_DIS_BIT = 6;
    localparam int SCAN_EVERY_BIT = 5;
    localparam int ALERT_REPLY_BIT = 4;
    localparam int LOW_POWER_BIT = 2;
    localparam int GROUP_SCAN_BIT = 6;
    localparam int WAKE_SCAN_BIT = 3;
    localparam int WAKE_GPIO_BIT = 2;
    localparam int WAKE_DATA_BIT = 1;
    localparam int WAKE_CLOCK_BIT = 0;
    localparam int SCAN_OUT_COUNT = 23;
    localparam logic [4:0] LAST_COLUMN = 5'h16;
    localparam logic [1:0] LINK_FORCE_COMPANION = 2'h2;
    localparam logic [1:0] LINK_FORCE_SMBUS = 2'h3;
    localparam logic [7:0] OSC_LINK_WR_MASK = 8'h1F;
    localparam logic [7:0] WAKE_WR_MASK = 8'h0F;
    // upper six address bits fixed, low bit from the select strap
    localparam logic [6:0] SMBUS_ADDR_BASE = 7'h38;
    // ********************
    // timing
    // ********************
    localparam int CLK_MHZ = 100;
    localparam int SMBUS_IDLE_MS = 75;
    localparam int COMPANION_IDLE_US = 75;
    localparam int SMBUS_IDLE_CYCLES = SMBUS_IDLE_MS * 1000 * CLK_MHZ;
    localparam int COMPANION_IDLE_CYCLES = COMPANION_IDLE_US * CLK_MHZ;
endpackage

// ==== core/keyscan_wakeup_control.sv ====
// keyscan drive, scan input capture, oscillator wakeup and link detect
`timescale 1ns/10ps
module keyscan_wakeup_control
    import keyscan_wakeup_pkg::*;
#(
    parameter int SMBUS_IDLE = SMBUS_IDLE_CYCLES,
    parameter int COMPANION_IDLE = COMPANION_IDLE_CYCLES,
    // arbitrary identity values
    parameter logic [7:0] PART_ID = 8'hA5,
    parameter logic [7:0] REVISION = 8'h01,
    parameter logic [7:0] MAKER_LOW = 8'h5A,
    parameter logic [7:0] MAKER_HIGH = 8'hC3
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic companion_link_clock,
    input wire logic companion_link_data,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic bus_busy,
    input wire logic addr_probe,
    input wire logic [6:0] addr_probe_value,
    input wire logic addr_select,
    input wire logic [31:0] gpio_pending,
    input wire logic [7:0] scan_in_line,
    output logic [SCAN_OUT_COUNT-1:0] scan_out_line_o,
    output logic [SCAN_OUT_COUNT-1:0] scan_out_line_oe,
    output logic companion_irq_n,
    output logic osc_stopped,
    output logic link_is_smbus,
    output logic link_is_companion,
    output logic alert_reply_active,
    output logic [6:0] slave_addr,
    output logic slave_addr_locked
);
    // ********************
    // link clock domain
    // ********************
    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic edge_toggle;
        logic sampled_data;
    } link_state_t;

    link_state_t lk_r, lk_nxt;

    always_comb begin
        lk_nxt = lk_r;
        lk_nxt.rst_s1 = rst;
        lk_nxt.rst_s2 = lk_r.rst_s1;
        if (lk_r.rst_s2) begin
            lk_nxt.edge_toggle = 1'b0;
            lk_nxt.sampled_data = 1'b1;
        end else begin
            lk_nxt.edge_toggle = ~lk_r.edge_toggle;
            lk_nxt.sampled_data = companion_link_data;
        end
    end

    // sampled on the falling clock edge, as the detect needs
    always_ff @(negedge companion_link_clock) begin
        lk_r <= lk_nxt;
    end

    // ********************
    // core clock domain
    // ********************
    typedef struct packed {
        logic [7:0] scan_s1;
        logic [7:0] scan_s2;
        logic [7:0] scan_prev;
        logic [2:0] tog_s;
        logic [1:0] samp_s;
        logic [1:0] sda_s;
        logic [1:0] scl_s;
        logic sda_prev;
        logic [1:0] strap_s;
        logic [7:0] scan_ctl;
        logic [7:0] scan_flags;
        logic [7:0] scan_irq_en;
        logic scan_armed;
        logic alert_reply_en;
        logic low_power_req;
        logic [1:0] link_choice;
        logic [3:0] wake_en;
        logic detected;
        logic detected_smbus;
        logic [22:0] idle_cnt;
        logic osc_stopped;
        logic soft_reset;
        logic addr_locked;
        logic [6:0] slave_addr;
        logic [7:0] rdata;
        logic [SCAN_OUT_COUNT-1:0] scan_oe;
        logic irq_n;
    } core_state_t;

    core_state_t st_r, st_nxt;

    logic [SCAN_OUT_COUNT-1:0] col_hit;
    logic [SCAN_OUT_COUNT-1:0] active_mask;
    logic [SCAN_OUT_COUNT-1:0] level;
    logic [3:0] bank_pending;
    logic [7:0] group_summary;
    logic scan_irq;
    logic smbus_active;
    logic companion_active;
    logic clock_edge;
    logic data_edge;
    logic start_seen;
    logic [7:0] falls;
    logic [7:0] flag_clear;
    logic [7:0] osc_link_rd;
    logic wake;

    genvar gi;
    generate
        for (gi = 0; gi < SCAN_OUT_COUNT; gi = gi + 1) begin : g_col
            assign col_hit[gi] = (st_r.scan_ctl[4:0] == 5'(gi));
        end
    endgenerate

    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_bank
            assign bank_pending[gi] = |gpio_pending[gi*8 +: 8];
        end
    endgenerate

    always_comb begin
        // level per column: picked column carries the active level
        if (st_r.scan_ctl[SCAN_EVERY_BIT]) begin
            active_mask = '1;
        end else if (st_r.scan_ctl[4:0] <= LAST_COLUMN) begin
            active_mask = col_hit;
        end else begin
            active_mask = '0;
        end
        if (st_r.scan_ctl[SCAN_DIS_BIT]) begin
            level = '1;
        end else if (st_r.scan_ctl[SCAN_POL_BIT]) begin
            level = active_mask;
        end else begin
            level = ~active_mask;
        end
    end

    assign scan_irq = |(st_r.scan_flags & st_r.scan_irq_en);
    assign group_summary = {1'b0, scan_irq, 2'b00, bank_pending};

    assign smbus_active = (st_r.link_choice == LINK_FORCE_SMBUS)
        || (!st_r.link_choice[1] && st_r.detected && st_r.detected_smbus);
    assign companion_active = (st_r.link_choice == LINK_FORCE_COMPANION)
        || (!st_r.link_choice[1] && st_r.detected && !st_r.detected_smbus);

    assign clock_edge = st_r.tog_s[2] ^ st_r.tog_s[1];
    assign data_edge = st_r.sda_s[1] ^ st_r.sda_prev;
    // data falling while clock high marks a start on either link
    assign start_seen = st_r.sda_prev && !st_r.sda_s[1] && st_r.scl_s[1];
    assign falls = st_r.scan_prev & ~st_r.scan_s2;
    assign flag_clear = (reg_wr && reg_addr == OFS_SCAN_FLAGS) ? reg_wdata : 8'h00;
    assign osc_link_rd = {3'b000, st_r.alert_reply_en, 1'b0, st_r.low_power_req,
        st_r.link_choice};

    always_comb begin
        wake = 1'b0;
        if (st_r.wake_en[WAKE_SCAN_BIT] && scan_irq) begin
            wake = 1'b1;
        end
        if (st_r.wake_en[WAKE_GPIO_BIT] && (|bank_pending)) begin
            wake = 1'b1;
        end
        if (st_r.wake_en[WAKE_DATA_BIT] && data_edge) begin
            wake = 1'b1;
        end
        if (st_r.wake_en[WAKE_CLOCK_BIT] && clock_edge) begin
            wake = 1'b1;
        end
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.scan_s1 = scan_in_line;
        st_nxt.scan_s2 = st_r.scan_s1;
        st_nxt.scan_prev = st_r.scan_s2;
        st_nxt.tog_s = {st_r.tog_s[1:0], lk_r.edge_toggle};
        st_nxt.samp_s = {st_r.samp_s[0], lk_r.sampled_data};
        st_nxt.sda_s = {st_r.sda_s[0], companion_link_data};
        st_nxt.scl_s = {st_r.scl_s[0], companion_link_clock};
        st_nxt.sda_prev = st_r.sda_s[1];
        st_nxt.strap_s = {st_r.strap_s[0], addr_select};
        st_nxt.soft_reset = 1'b0;

        st_nxt.scan_flags = st_r.scan_flags & ~flag_clear;
        if (st_r.scan_armed && (|falls)) begin
            st_nxt.scan_flags = st_nxt.scan_flags | falls;
            st_nxt.scan_armed = 1'b0;
        end else if (&st_r.scan_s2) begin
            st_nxt.scan_armed = 1'b1;
        end

        if (reg_wr) begin
            case (reg_addr)
                OFS_SCAN_CTL: begin
                    st_nxt.scan_ctl = reg_wdata;
                end
                OFS_SCAN_IRQ_EN: begin
                    st_nxt.scan_irq_en = reg_wdata;
                end
                OFS_SOFT_RESET: begin
                    st_nxt.soft_reset = reg_wdata[0];
                end
                OFS_OSC_LINK_CTL: begin
                    st_nxt.alert_reply_en = reg_wdata[ALERT_REPLY_BIT];
                    st_nxt.low_power_req = reg_wdata[LOW_POWER_BIT];
                    st_nxt.link_choice = reg_wdata[1:0];
                end
                OFS_WAKE_EN: begin
                    st_nxt.wake_en = reg_wdata[3:0];
                end
                default: begin
                end
            endcase
        end

        if (reg_rd) begin
            case (reg_addr)
                OFS_SCAN_CTL: st_nxt.rdata = st_r.scan_ctl;
                OFS_SCAN_LEVEL: st_nxt.rdata = st_r.scan_s2;
                OFS_SCAN_FLAGS: st_nxt.rdata = st_r.scan_flags;
                OFS_SCAN_IRQ_EN: st_nxt.rdata = st_r.scan_irq_en;
                OFS_GROUP_SUMMARY: st_nxt.rdata = group_summary;
                OFS_OSC_LINK_CTL: st_nxt.rdata = osc_link_rd & OSC_LINK_WR_MASK;
                OFS_WAKE_EN: st_nxt.rdata = {4'h0, st_r.wake_en} & WAKE_WR_MASK;
                OFS_PART_ID: st_nxt.rdata = PART_ID;
                OFS_REVISION: st_nxt.rdata = REVISION;
                OFS_MAKER_LOW: st_nxt.rdata = MAKER_LOW;
                OFS_MAKER_HIGH: st_nxt.rdata = MAKER_HIGH;
                default: st_nxt.rdata = 8'h00;
            endcase
        end

        // first falling clock from idle picks the link
        if (!st_r.detected && clock_edge) begin
            st_nxt.detected = 1'b1;
            st_nxt.detected_smbus = !st_r.samp_s[1];
        end
        // inactivity timeout, reloaded by a start
        if (start_seen || (!st_r.detected && clock_edge)) begin
            if (st_r.detected ? st_r.detected_smbus : !st_r.samp_s[1]) begin
                st_nxt.idle_cnt = 23'(SMBUS_IDLE);
            end else begin
                st_nxt.idle_cnt = 23'(COMPANION_IDLE);
            end
        end else if (st_r.detected) begin
            if (st_r.idle_cnt == 23'h000000) begin
                st_nxt.detected = 1'b0;
            end else begin
                st_nxt.idle_cnt = st_r.idle_cnt - 23'h000001;
            end
        end

        // latch strap address on first match of upper five bits
        if (!st_r.addr_locked) begin
            st_nxt.slave_addr = SMBUS_ADDR_BASE | {6'h00, st_r.strap_s[1]};
            if (addr_probe && addr_probe_value[6:2] == SMBUS_ADDR_BASE[6:2]) begin
                st_nxt.addr_locked = 1'b1;
            end
        end

        // stop only when idle with nothing pending
        if (st_r.osc_stopped) begin
            if (wake || !st_r.low_power_req) begin
                st_nxt.osc_stopped = 1'b0;
            end
        end else if (st_r.low_power_req && !bus_busy && !scan_irq
            && !(|bank_pending) && !start_seen) begin
            st_nxt.osc_stopped = 1'b1;
        end

        // open drain: enable only to pull low
        st_nxt.scan_oe = ~level;
        // interrupt line from enabled scan flags and gpio banks
        st_nxt.irq_n = !(scan_irq || (|bank_pending));

        if (rst || st_r.soft_reset) begin
            st_nxt.scan_ctl = SCAN_CTL_RESET;
            st_nxt.scan_flags = 8'h00;
            st_nxt.scan_irq_en = 8'h00;
            st_nxt.scan_armed = 1'b1;
            st_nxt.alert_reply_en = 1'b0;
            st_nxt.low_power_req = 1'b0;
            st_nxt.wake_en = 4'h0;
            st_nxt.osc_stopped = 1'b0;
            st_nxt.soft_reset = 1'b0;
            st_nxt.addr_locked = 1'b0;
            st_nxt.rdata = 8'h00;
            st_nxt.irq_n = 1'b1;
            // default control disables scanning, so every output floats high
            st_nxt.scan_oe = '0;
            if (rst) begin
                st_nxt.link_choice = 2'b00;
                st_nxt.detected = 1'b0;
                st_nxt.detected_smbus = 1'b0;
                st_nxt.idle_cnt = 23'h000000;
                st_nxt.slave_addr = SMBUS_ADDR_BASE;
                st_nxt.scan_s1 = 8'hFF;
                st_nxt.scan_s2 = 8'hFF;
                st_nxt.scan_prev = 8'hFF;
                st_nxt.tog_s = 3'b000;
                st_nxt.samp_s = 2'b11;
                st_nxt.sda_s = 2'b11;
                st_nxt.scl_s = 2'b11;
                st_nxt.sda_prev = 1'b1;
                st_nxt.strap_s = 2'b00;
            end
            // soft reset keeps link choice and detection
        end
    end

    always_ff @(posedge core_clk) begin
        st_r <= st_nxt;
    end

    assign reg_rdata = st_r.rdata;
    assign scan_out_line_o = '0;
    assign scan_out_line_oe = st_r.scan_oe;
    assign companion_irq_n = st_r.irq_n;
    assign osc_stopped = st_r.osc_stopped;
    assign slave_addr = st_r.slave_addr;
    assign slave_addr_locked = st_r.addr_locked;

    logic alert_q_r;
    logic smbus_q_r;
    logic companion_q_r;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            alert_q_r <= 1'b0;
            smbus_q_r <= 1'b0;
            companion_q_r <= 1'b0;
        end else begin
            alert_q_r <= st_r.alert_reply_en && smbus_active;
            smbus_q_r <= smbus_active;
            companion_q_r <= companion_active;
        end
    end
    assign alert_reply_active = alert_q_r;
    assign link_is_smbus = smbus_q_r;
    assign link_is_companion = companion_q_r;
endmodule // keyscan_wakeup_control

// ==== testbench/keyscan_wakeup_control_asserts.sv ====
// port-level assertions for the keyscan and wakeup control block
`timescale 1ns/10ps
module keyscan_wakeup_control_asserts
    import keyscan_wakeup_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic bus_busy,
    input wire logic addr_probe,
    input wire logic [6:0] addr_probe_value,
    input wire logic [31:0] gpio_pending,
    input wire logic [7:0] scan_in_line,
    input wire logic [SCAN_OUT_COUNT-1:0] scan_out_line_o,
    input wire logic [SCAN_OUT_COUNT-1:0] scan_out_line_oe,
    input wire logic companion_irq_n,
    input wire logic osc_stopped,
    input wire logic link_is_smbus,
    input wire logic link_is_companion,
    input wire logic alert_reply_active,
    input wire logic slave_addr_locked
);
    logic scan_wr;
    logic [3:0] cause_cnt_r;
    logic [3:0] cause_cnt_nxt;
    logic [7:0] scan_prev_r;
    assign scan_wr = reg_wr && reg_addr == OFS_SCAN_CTL;
    // irq may only fall a few cycles after a scan fall, a gpio event or a write
    always_comb begin
        cause_cnt_nxt = (cause_cnt_r == 4'h0) ? 4'h0 : cause_cnt_r - 4'h1;
        if (reg_wr || (|gpio_pending) || (|(scan_prev_r & ~scan_in_line))) begin
            cause_cnt_nxt = 4'hA;
        end
    end
    always_ff @(posedge core_clk) begin
        cause_cnt_r <= rst ? 4'h0 : cause_cnt_nxt;
        scan_prev_r <= scan_in_line;
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    sequence link_wr_s(v);
        reg_wr && reg_addr == OFS_OSC_LINK_CTL && reg_wdata[1:0] == v;
    endsequence
    open_drain_a: assert property (
        scan_out_line_o == '0) else $error("scan data not low");
    scan_off_a: assert property (
        scan_wr && reg_wdata[6] |-> ##2 scan_out_line_oe == '0) else $error("scan off");
    scan_every_a: assert property (
        scan_wr && reg_wdata[6:5] == 2'b01 |->
        ##2 scan_out_line_oe == {SCAN_OUT_COUNT{!$past(reg_wdata[7], 2)}}) else $error("every");
    scan_column_a: assert property (
        scan_wr && reg_wdata[6:5] == 2'b00 && reg_wdata[4:0] <= LAST_COLUMN |-> ##2
        $countones(scan_out_line_oe) == ($past(reg_wdata[7], 2) ? SCAN_OUT_COUNT - 1 : 1) &&
        scan_out_line_oe[$past(reg_wdata[4:0], 2)] != $past(reg_wdata[7], 2))
        else $error("column");
    irq_cause_a: assert property (
        $fell(companion_irq_n) |-> cause_cnt_r != 4'h0) else $error("irq without cause");
    osc_stop_a: assert property (
        $rose(osc_stopped) |-> !$past(bus_busy) && $past(gpio_pending) == 32'h0)
        else $error("stop while busy");
    alert_link_a: assert property (
        $rose(alert_reply_active) |-> link_is_smbus) else $error("alert off smbus");
    force_smbus_a: assert property (
        link_wr_s(LINK_FORCE_SMBUS) |-> ##[1:3] link_is_smbus && !link_is_companion)
        else $error("smbus force");
    force_comp_a: assert property (
        link_wr_s(LINK_FORCE_COMPANION) |-> ##[1:3] link_is_companion && !link_is_smbus)
        else $error("companion force");
    addr_lock_a: assert property (
        addr_probe && addr_probe_value[6:2] == SMBUS_ADDR_BASE[6:2] |->
        ##[1:3] slave_addr_locked) else $error("address not latched");
endmodule // keyscan_wakeup_control_asserts

// ==== testbench/host_model.sv ====
// host controller model: register strobes and link pins
`timescale 1ns/10ps
module host_model
    import keyscan_wakeup_pkg::*;
(
    input wire logic core_clk,
    input wire logic [7:0] reg_rdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic companion_link_clock,
    output logic companion_link_data
);
    // link lines rest high as on a pulled-up bus; the clock moves only in frames and lone pulses
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        companion_link_clock = 1'b1;
        companion_link_data = 1'b1;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask
    task automatic frame(input logic lead, input int n);
        companion_link_data = lead;
        repeat (n) begin
            #3;
            companion_link_clock = 1'b0;
            #3;
            companion_link_clock = 1'b1;
        end
        #3;
        companion_link_data = 1'b1;
    endtask
    // a lone line pulse must outlast a core clock period or the sync flops miss it
    task automatic pulse(input logic on_clock);
        if (on_clock) companion_link_clock = 1'b0;
        else companion_link_data = 1'b0;
        #13;
        companion_link_clock = 1'b1;
        companion_link_data = 1'b1;
    endtask
endmodule // host_model

// ==== testbench/test_keyscan_wakeup_control.sv ====
// self-checking bench for the keyscan and wakeup control block
`timescale 1ns/10ps
module test_keyscan_wakeup_control
    import keyscan_wakeup_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic bus_busy = 1'b0;
    logic addr_probe = 1'b0;
    logic [6:0] addr_probe_value = 7'h00;
    logic addr_select = 1'b1;
    logic [31:0] gpio_pending = 32'h0;
    logic [7:0] scan_in_line = 8'hFF;
    logic reg_wr, reg_rd, link_clk, link_dat, irq_n, osc_stopped;
    logic is_smb, is_comp, alert, locked;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [6:0] slave_addr;
    logic [SCAN_OUT_COUNT-1:0] so_o, so_oe;
    int n_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    always #5 core_clk = ~core_clk;
    // part code 3C is arbitrary; idle counts shortened for the run
    keyscan_wakeup_control #(.SMBUS_IDLE(200), .COMPANION_IDLE(20), .PART_ID(8'h3C)) dut (
        .core_clk(core_clk), .rst(rst), .companion_link_clock(link_clk),
        .companion_link_data(link_dat), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .bus_busy(bus_busy), .addr_probe(addr_probe), .addr_probe_value(addr_probe_value),
        .addr_select(addr_select), .gpio_pending(gpio_pending), .scan_in_line(scan_in_line),
        .scan_out_line_o(so_o), .scan_out_line_oe(so_oe), .companion_irq_n(irq_n),
        .osc_stopped(osc_stopped), .link_is_smbus(is_smb), .link_is_companion(is_comp),
        .alert_reply_active(alert), .slave_addr(slave_addr), .slave_addr_locked(locked));
    host_model host (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .companion_link_clock(link_clk), .companion_link_data(link_dat));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, d);
        chk($sformatf("reg %h", a), 32'(exp), 32'(d));
    endtask
    task automatic waitc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // a wake is brief when nothing stays pending, so watch a short window
    task automatic wake_seen(input string nm, input logic exp);
        logic seen = 1'b0;
        repeat (8) begin
            @(negedge core_clk);
            if (osc_stopped === 1'b0) seen = 1'b1;
        end
        chk(nm, 32'(seen), 32'(exp));
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_link();
        host.frame(1'b0, 9);
        waitc(4);
        chk("auto smbus", 32'({is_comp, is_smb}), 1);
        host.wr(OFS_OSC_LINK_CTL, 8'h13);
        waitc(3);
        chk("alert", 32'(alert), 1);
        host.wr(OFS_OSC_LINK_CTL, 8'h12);
        waitc(3);
        chk("companion", 32'({is_comp, is_smb, alert}), 4);
        host.wr(OFS_OSC_LINK_CTL, 8'h10);
        waitc(300);
        chk("idle", 32'({is_comp, is_smb}), 0);
        host.frame(1'b1, 9);
        waitc(4);
        chk("auto comp", 32'({is_comp, alert}), 2);
        host.wr(OFS_OSC_LINK_CTL, 8'h13);
        rchk(OFS_OSC_LINK_CTL, 8'h13);
        host.wr(OFS_SOFT_RESET, 8'h01);
        rchk(OFS_OSC_LINK_CTL, 8'h03);
        rchk(OFS_SOFT_RESET, 8'h00);
        rchk(OFS_SCAN_CTL, SCAN_CTL_RESET);
        chk("kept", 32'(is_smb), 1);
    endtask
    task automatic t_regs();
        logic [7:0] a [6] = '{8'h43, 8'h42, 8'hFB, 8'hF6, 8'h50, 8'hFC};
        logic [7:0] e [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3C};
        foreach (a[i]) rchk(a[i], e[i]);
        host.wr(OFS_WAKE_EN, 8'hFF);
        rchk(OFS_WAKE_EN, 8'h0F);
        host.wr(OFS_PART_ID, 8'h00);
        rchk(OFS_PART_ID, 8'h3C);
    endtask
    task automatic t_scan_out();
        logic [7:0] c [8] = '{8'h45, 8'h05, 8'h85, 8'h16, 8'h17, 8'h9F, 8'h20, 8'hA0};
        logic [SCAN_OUT_COUNT-1:0] e;
        foreach (c[i]) begin
            host.wr(OFS_SCAN_CTL, c[i]);
            waitc(3);
            e = c[i][7] ? '1 : '0;
            if (c[i][6]) e = '0;
            else if (c[i][5]) e = ~e;
            else if (c[i][4:0] <= LAST_COLUMN) e = e ^ (23'h1 << c[i][4:0]);
            chk("scan oe", 32'(e), 32'(so_oe));
            chk("scan data", 32'(so_o), 0);
        end
    endtask
    task automatic t_scan_in();
        host.wr(OFS_SCAN_IRQ_EN, 8'h01);
        scan_in_line = 8'hFE;
        waitc(6);
        chk("irq", 32'(irq_n), 0);
        rchk(OFS_SCAN_FLAGS, 8'h01);
        rchk(OFS_GROUP_SUMMARY, 8'h40);
        rchk(OFS_SCAN_LEVEL, 8'hFE);
        scan_in_line = 8'hFC;
        waitc(6);
        host.wr(OFS_SCAN_FLAGS, 8'h00);
        rchk(OFS_SCAN_FLAGS, 8'h01);
        host.wr(OFS_SCAN_FLAGS, 8'h01);
        rchk(OFS_SCAN_FLAGS, 8'h00);
        chk("irq off", 32'(irq_n), 1);
        scan_in_line = 8'hFF;
        waitc(6);
        scan_in_line = 8'hFD;
        waitc(6);
        rchk(OFS_SCAN_FLAGS, 8'h02);
        chk("masked", 32'(irq_n), 1);
        rchk(OFS_GROUP_SUMMARY, 8'h00);
        host.wr(OFS_SCAN_FLAGS, 8'h02);
        scan_in_line = 8'hFF;
        for (int b = 0; b < 4; b++) begin
            gpio_pending = 32'h80 << (8 * b);
            waitc(2);
            rchk(OFS_GROUP_SUMMARY, 8'h01 << b);
        end
        gpio_pending = 32'h0;
    endtask
    task automatic t_osc();
        host.wr(OFS_WAKE_EN, 8'h04);
        bus_busy = 1'b1;
        host.wr(OFS_OSC_LINK_CTL, 8'h17);
        waitc(5);
        chk("busy run", 32'(osc_stopped), 0);
        bus_busy = 1'b0;
        waitc(5);
        chk("stop", 32'(osc_stopped), 1);
        gpio_pending = 32'h1;
        wake_seen("gpio wake", 1'b1);
        gpio_pending = 32'h0;
        host.wr(OFS_WAKE_EN, 8'h0A);
        waitc(5);
        host.pulse(1'b0);
        wake_seen("data wake", 1'b1);
        host.pulse(1'b1);
        wake_seen("clock off", 1'b0);
        scan_in_line = 8'hFE;
        wake_seen("scan wake", 1'b1);
        host.wr(OFS_SCAN_FLAGS, 8'h01);
        scan_in_line = 8'hFF;
        host.wr(OFS_WAKE_EN, 8'h00);
        waitc(5);
        gpio_pending = 32'h1;
        wake_seen("gpio off", 1'b0);
        gpio_pending = 32'h0;
        host.wr(OFS_OSC_LINK_CTL, 8'h13);
        waitc(3);
        chk("run", 32'(osc_stopped), 0);
    endtask
    task automatic probe(input logic [6:0] v, input logic exp);
        addr_probe_value = v;
        addr_probe = 1'b1;
        waitc(1);
        addr_probe = 1'b0;
        waitc(3);
        chk("lock", 32'(locked), 32'(exp));
    endtask
    task automatic final_report();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            final_report();
        end
    end
    initial begin
        // the link side resets only on its own falling edges
        fork
            #20 host.frame(1'b1, 4);
        join_none
        waitc(16);
        rst = 1'b0;
        waitc(2);
        t_link();
        t_regs();
        t_scan_out();
        t_scan_in();
        t_osc();
        chk("addr", 32'(slave_addr), 32'(SMBUS_ADDR_BASE | 7'h01));
        probe(7'h20, 1'b0);
        probe(7'h39, 1'b1);
        final_report();
    end
endmodule // test_keyscan_wakeup_control
bind keyscan_wakeup_control keyscan_wakeup_control_asserts chk_i (
    .core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .bus_busy(bus_busy), .addr_probe(addr_probe),
    .addr_probe_value(addr_probe_value), .gpio_pending(gpio_pending),
    .scan_in_line(scan_in_line), .scan_out_line_o(scan_out_line_o),
    .scan_out_line_oe(scan_out_line_oe), .companion_irq_n(companion_irq_n),
    .osc_stopped(osc_stopped), .link_is_smbus(link_is_smbus),
    .link_is_companion(link_is_companion), .alert_reply_active(alert_reply_active),
    .slave_addr_locked(slave_addr_locked));
